// >>> cfgx_app_end.sv
// Application end: samples exported data, drives hot-plug events
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "cfgx_params.svh"
module cfgx_app_end
    import cfgx_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    // Interrupt
    output var  logic        irq,
    // Link to core
    cfgx_link_if.app         lk
);
    logic                 mode_ep_r;
    cfgx_hp_t             hp_drive_r;
    logic [2:0]           hp_cap_r;
    cfgx_index_t          watch_idx_r;
    cfgx_hp_t             hp_out_r;
    logic [2:0]           ctgl_r;
    logic [2:0]           stgl_r;
    logic                 ctrl_edge;
    logic                 sts_edge;
    cfgx_index_t          last_idx_r;
    cfgx_word_t           last_ctrl_r;
    cfgx_word_t           watch_data_r;
    logic [127:0]         sts_cap_r;
    cfgx_irq_t            ist_r;
    cfgx_irq_t            imask_r;
    cfgx_irq_t            ev;
    logic                 irq_r;
    logic                 wr_pend_r;
    logic [`CFGX_A_W-1:0] waddr_r;
    logic [31:0]          rd_nxt;
    logic [31:0]          hrdata_r;
    logic                 aphase;
    logic                 wr_hit_ist;

    assign aphase = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r   <= '0;
        end else if (hready) begin
            wr_pend_r <= aphase & hwrite;
            waddr_r   <= haddr[`CFGX_A_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ep_r   <= 1'b1;
            hp_drive_r  <= '0;
            hp_cap_r    <= '0;
            watch_idx_r <= '0;
            imask_r     <= '0;
        end else if (wr_pend_r) begin
            unique case (waddr_r)
                `CFGX_REG_MODE:      mode_ep_r   <= hwdata[0];
                `CFGX_REG_HP_DRIVE:  hp_drive_r  <= hwdata[`CFGX_HP_W-1:0];
                `CFGX_REG_HP_CAP:    hp_cap_r    <= hwdata[2:0];
                `CFGX_REG_WATCH_IDX: watch_idx_r <= hwdata[`CFGX_IDX_W-1:0];
                `CFGX_REG_IRQ_MASK:  imask_r     <= hwdata[`CFGX_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Absent slot hardware forces its event low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hp_out_r <= '0;
        end else if (mode_ep_r) begin
            hp_out_r <= '0;
        end else begin
            hp_out_r[`CFGX_HP_BUTTON] <= hp_drive_r[`CFGX_HP_BUTTON]
                & hp_cap_r[`CFGX_CAP_BUTTON];
            hp_out_r[`CFGX_HP_PRESENCE] <=
                hp_drive_r[`CFGX_HP_PRESENCE];
            hp_out_r[`CFGX_HP_LATCH] <= hp_drive_r[`CFGX_HP_LATCH]
                & hp_cap_r[`CFGX_CAP_LATCH];
            hp_out_r[`CFGX_HP_PFAULT] <= hp_drive_r[`CFGX_HP_PFAULT]
                & hp_cap_r[`CFGX_CAP_PWR];
            hp_out_r[`CFGX_HP_PWR_STS] <= hp_drive_r[`CFGX_HP_PWR_STS]
                & hp_cap_r[`CFGX_CAP_PWR];
        end
    end

    // Two stages, then an edge stage; the control bus holds long enough to wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctgl_r <= '0;
            stgl_r <= '0;
        end else begin
            ctgl_r <= {ctgl_r[1:0], lk.cfg_ctrl_update_toggle};
            stgl_r <= {stgl_r[1:0], lk.cfg_status_update_toggle};
        end
    end

    assign ctrl_edge = ctgl_r[2] ^ ctgl_r[1];
    assign sts_edge  = stgl_r[2] ^ stgl_r[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_idx_r   <= '0;
            last_ctrl_r  <= '0;
            watch_data_r <= '0;
        end else if (ctrl_edge) begin
            last_idx_r  <= lk.cfg_export_index;
            last_ctrl_r <= lk.cfg_export_ctrl_bus;
            if (lk.cfg_export_index == watch_idx_r) begin
                watch_data_r <= lk.cfg_export_ctrl_bus;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_cap_r <= '0;
        end else if (sts_edge) begin
            sts_cap_r <= {5'h00, lk.cfg_export_status_bus};
        end
    end

    assign ev[`CFGX_IRQ_WATCH] = ctrl_edge
        & (lk.cfg_export_index == watch_idx_r);
    assign ev[`CFGX_IRQ_STS] = sts_edge
        & (lk.cfg_export_status_bus != sts_cap_r[`CFGX_STS_W-1:0]);
    assign ev[`CFGX_IRQ_CMD] = sts_edge
        & lk.cfg_export_status_bus[`CFGX_STS_CMD_BIT]
        & ~sts_cap_r[`CFGX_STS_CMD_BIT];

    assign wr_hit_ist = wr_pend_r & (waddr_r == `CFGX_REG_IRQ_STS);

    // Write-one-to-clear; a new event in the same cycle stays set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ist_r <= '0;
        end else begin
            ist_r <= ev | (ist_r
                & ~(wr_hit_ist ? hwdata[`CFGX_IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ist_r & imask_r);
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (haddr[`CFGX_A_W-1:0])
            `CFGX_REG_MODE:       rd_nxt[0] = mode_ep_r;
            `CFGX_REG_HP_DRIVE:   rd_nxt[`CFGX_HP_W-1:0] = hp_drive_r;
            `CFGX_REG_HP_CAP:     rd_nxt[2:0] = hp_cap_r;
            `CFGX_REG_WATCH_IDX:  rd_nxt[`CFGX_IDX_W-1:0] = watch_idx_r;
            `CFGX_REG_LAST_IDX:   rd_nxt[`CFGX_IDX_W-1:0] = last_idx_r;
            `CFGX_REG_LAST_CTRL:  rd_nxt = last_ctrl_r;
            `CFGX_REG_WATCH_DATA: rd_nxt = watch_data_r;
            `CFGX_REG_STS0:       rd_nxt = sts_cap_r[31:0];
            `CFGX_REG_STS1:       rd_nxt = sts_cap_r[63:32];
            `CFGX_REG_STS2:       rd_nxt = sts_cap_r[95:64];
            `CFGX_REG_STS3:       rd_nxt = sts_cap_r[127:96];
            `CFGX_REG_IRQ_STS:    rd_nxt[`CFGX_IRQ_W-1:0] = ist_r;
            `CFGX_REG_IRQ_MASK:   rd_nxt[`CFGX_IRQ_W-1:0] = imask_r;
            default: ;
        endcase
    end

    // Zero wait states: read data is fixed at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (aphase & ~hwrite) begin
            hrdata_r <= rd_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign irq       = irq_r;
    assign lk.hotplug_event_inputs = hp_out_r;
endmodule : cfgx_app_end
`default_nettype wire

// >>> cfgx_params.svh
// Constants for the configuration export and hot-plug link
`ifndef CFGX_PARAMS_SVH
`define CFGX_PARAMS_SVH

`define CFGX_IDX_W          7
`define CFGX_FUNC_MSB       6
`define CFGX_FUNC_LSB       4
`define CFGX_SUB_MSB        3
`define CFGX_SUB_LSB        0
`define CFGX_CTRL_W         32
`define CFGX_STS_W          123
`define CFGX_HP_W           5
`define CFGX_NUM_FUNC       8
`define CFGX_TBL_DEPTH      128

`define CFGX_UPDATE_CYCLES  8
`define CFGX_TICK_CNT_W     3
`define CFGX_TICK_LAST      3'h7

`define CFGX_F0_STS_W       53
`define CFGX_FN_STS_W       10
`define CFGX_STS_DLL_BIT    48
`define CFGX_STS_CMD_BIT    47

`define CFGX_HP_BUTTON      0
`define CFGX_HP_PRESENCE    1
`define CFGX_HP_LATCH       2
`define CFGX_HP_PFAULT      3
`define CFGX_HP_PWR_STS     4

`define CFGX_CAP_BUTTON     0
`define CFGX_CAP_PWR        1
`define CFGX_CAP_LATCH      2

`define CFGX_FLAG_CMD       0
`define CFGX_FLAG_DLL       1

`define CFGX_IRQ_W          3
`define CFGX_IRQ_WATCH      0
`define CFGX_IRQ_STS        1
`define CFGX_IRQ_CMD        2

`define CFGX_A_W            8
`define CFGX_REG_MODE       8'h00
`define CFGX_REG_HP_DRIVE   8'h04
`define CFGX_REG_HP_CAP     8'h08
`define CFGX_REG_WATCH_IDX  8'h0c
`define CFGX_REG_LAST_IDX   8'h10
`define CFGX_REG_LAST_CTRL  8'h14
`define CFGX_REG_WATCH_DATA 8'h18
`define CFGX_REG_STS0       8'h20
`define CFGX_REG_STS1       8'h24
`define CFGX_REG_STS2       8'h28
`define CFGX_REG_STS3       8'h2c
`define CFGX_REG_IRQ_STS    8'h30
`define CFGX_REG_IRQ_MASK   8'h34

`endif

// >>> cfgx_pkg.sv
// Types shared by both ends of the configuration export link
`include "cfgx_params.svh"
package cfgx_pkg;
    typedef logic [`CFGX_IDX_W-1:0]  cfgx_index_t;
    typedef logic [`CFGX_CTRL_W-1:0] cfgx_word_t;
    typedef logic [`CFGX_STS_W-1:0]  cfgx_status_t;
    typedef logic [`CFGX_HP_W-1:0]   cfgx_hp_t;
    typedef logic [`CFGX_IRQ_W-1:0]  cfgx_irq_t;
endpackage : cfgx_pkg

// >>> cfgx_link_if.sv
// Interface joining the core end and the application end
`timescale 1ns/10ps
`default_nettype none
interface cfgx_link_if;
    import cfgx_pkg::*;
    cfgx_index_t  cfg_export_index;
    cfgx_word_t   cfg_export_ctrl_bus;
    logic         cfg_ctrl_update_toggle;
    cfgx_status_t cfg_export_status_bus;
    logic         cfg_status_update_toggle;
    cfgx_hp_t     hotplug_event_inputs;

    modport dev (
        output cfg_export_index,
        output cfg_export_ctrl_bus,
        output cfg_ctrl_update_toggle,
        output cfg_export_status_bus,
        output cfg_status_update_toggle,
        input  hotplug_event_inputs
    );

    modport app (
        input  cfg_export_index,
        input  cfg_export_ctrl_bus,
        input  cfg_ctrl_update_toggle,
        input  cfg_export_status_bus,
        input  cfg_status_update_toggle,
        output hotplug_event_inputs
    );
endinterface : cfgx_link_if
`default_nettype wire

// >>> cfgx_tick_div.sv
// Divider giving a one-cycle pulse every update period
`timescale 1ns/10ps
`default_nettype none
`include "cfgx_params.svh"
module cfgx_tick_div
    import cfgx_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Update pulse
    output var  logic tick
);
    logic [`CFGX_TICK_CNT_W-1:0] cnt_r;
    logic                        tick_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + `CFGX_TICK_CNT_W'(1);
        end
    end

    // Counter wraps naturally, so the pulse period is a power of two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r == `CFGX_TICK_LAST);
        end
    end

    assign tick = tick_r;
endmodule : cfgx_tick_div
`default_nettype wire

// >>> cfgx_core_end.sv
// Core end: exports configuration contents, status and slot flags
//
// Operation
// - Index advances once every 8 clocks
// - Index holds function high, sub-index low
// - Control bus shows contents at index
// - Control toggle flips at each bus change
// - Status bus refreshed every clock cycle
// - Function 0 bits 52:0, then ten-bit groups
// - Status toggle flips every update period
// - Hot-plug inputs zero outside root slot mode
// - Bit 0: attention button, else tied low
// - Bit 1: presence change detected
// - Bit 2: latch open, else tied low
// - Bit 3: power fault, else tied low
// - Bit 4 mirrors power control, sets done
// - Status bit 48 link change, 47 done
`timescale 1ns/10ps
`default_nettype none
`include "cfgx_params.svh"
module cfgx_core_end
    import cfgx_pkg::*;
(
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Link to application
    cfgx_link_if.dev          lk,
    // Configuration table load
    input  wire logic         cfg_wr_en,
    input  wire cfgx_index_t  cfg_wr_index,
    input  wire cfgx_word_t   cfg_wr_data,
    // Raw status and mode
    input  wire cfgx_status_t sts_in,
    input  wire logic [`CFGX_NUM_FUNC-1:0] func_en,
    input  wire logic         root_port_mode,
    input  wire logic         slot_cap_en,
    input  wire logic         link_active,
    // Slot flag service
    input  wire logic [1:0]   slot_flag_clr,
    output var  logic [1:0]   slot_flags,
    output var  cfgx_hp_t     hotplug_events
);
    cfgx_word_t   tbl_mem [`CFGX_TBL_DEPTH];
    logic         tick;
    cfgx_index_t  idx_r;
    cfgx_index_t  idx_nxt;
    cfgx_word_t   ctrl_r;
    logic         ctrl_tgl_r;
    cfgx_status_t sts_r;
    logic         sts_tgl_r;
    logic         hp_en;
    cfgx_hp_t     hp_q_r;
    logic         pwr_prev_r;
    logic         link_prev_r;
    logic         cmd_flag_r;
    logic         dll_flag_r;
    logic         pwr_change;
    logic         link_change;
    wire  logic [`CFGX_STS_W-1:0] sts_masked;
    logic [2:0]   cur_func;
    logic [3:0]   cur_sub;

    cfgx_tick_div i_cfgx_tick_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    // Table is data only; contents undefined until loaded
    always_ff @(posedge hclk) begin
        if (cfg_wr_en) begin
            tbl_mem[cfg_wr_index] <= cfg_wr_data;
        end
    end

    assign idx_nxt = idx_r + `CFGX_IDX_W'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= '0;
        end else if (tick) begin
            idx_r <= idx_nxt;
        end
    end

    // Fields of the presented index
    assign cur_func = idx_r[`CFGX_FUNC_MSB:`CFGX_FUNC_LSB];
    assign cur_sub  = idx_r[`CFGX_SUB_MSB:`CFGX_SUB_LSB];

    // Contents change with the index in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= '0;
        end else if (tick) begin
            ctrl_r <= tbl_mem[idx_nxt];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_tgl_r <= 1'b0;
        end else if (tick) begin
            ctrl_tgl_r <= ~ctrl_tgl_r;
        end
    end

    // Hot-plug inputs count only in root port mode with a slot
    assign hp_en = root_port_mode & slot_cap_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hp_q_r <= '0;
        end else begin
            hp_q_r <= hp_en ? lk.hotplug_event_inputs : '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_prev_r <= 1'b0;
        end else begin
            pwr_prev_r <= hp_q_r[`CFGX_HP_PWR_STS];
        end
    end

    // Power status following its control marks a finished command
    assign pwr_change = hp_q_r[`CFGX_HP_PWR_STS] ^ pwr_prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_prev_r <= 1'b0;
        end else begin
            link_prev_r <= link_active;
        end
    end

    assign link_change = link_active ^ link_prev_r;

    // Set beats clear so no event is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_flag_r <= 1'b0;
        end else if (pwr_change) begin
            cmd_flag_r <= 1'b1;
        end else if (slot_flag_clr[`CFGX_FLAG_CMD]) begin
            cmd_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dll_flag_r <= 1'b0;
        end else if (link_change) begin
            dll_flag_r <= 1'b1;
        end else if (slot_flag_clr[`CFGX_FLAG_DLL]) begin
            dll_flag_r <= 1'b0;
        end
    end

    // Function 0 block with slot flags folded in
    assign sts_masked[`CFGX_F0_STS_W-1:`CFGX_STS_DLL_BIT+1] =
        func_en[0] ? sts_in[`CFGX_F0_STS_W-1:`CFGX_STS_DLL_BIT+1] : '0;
    assign sts_masked[`CFGX_STS_DLL_BIT] = dll_flag_r;
    assign sts_masked[`CFGX_STS_CMD_BIT] = cmd_flag_r;
    assign sts_masked[`CFGX_STS_CMD_BIT-1:0] =
        func_en[0] ? sts_in[`CFGX_STS_CMD_BIT-1:0] : '0;

    // Further functions each take one ten-bit group; absent ones read 0
    genvar g;
    generate
        for (g = 1; g < `CFGX_NUM_FUNC; g++) begin : g_func
            localparam int BASE = `CFGX_F0_STS_W + (g-1)*`CFGX_FN_STS_W;
            assign sts_masked[BASE +: `CFGX_FN_STS_W] =
                func_en[g] ? sts_in[BASE +: `CFGX_FN_STS_W] : '0;
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_r <= '0;
        end else begin
            sts_r <= sts_masked;
        end
    end

    // Strobe paces the far end; the bus itself never waits for it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_tgl_r <= 1'b0;
        end else if (tick) begin
            sts_tgl_r <= ~sts_tgl_r;
        end
    end

    assign lk.cfg_export_index         = {cur_func, cur_sub};
    assign lk.cfg_export_ctrl_bus      = ctrl_r;
    assign lk.cfg_ctrl_update_toggle   = ctrl_tgl_r;
    assign lk.cfg_export_status_bus    = sts_r;
    assign lk.cfg_status_update_toggle = sts_tgl_r;
    assign slot_flags     = {dll_flag_r, cmd_flag_r};
    assign hotplug_events = hp_q_r;
endmodule : cfgx_core_end
`default_nettype wire

// >>> cfgx_link_assertions.sv
// Concurrent checks on the configuration export link
`timescale 1ns/10ps
`default_nettype none
module cfgx_link_assertions
    import cfgx_pkg::*;
(
    // Clock and reset
    input wire logic         hclk,
    input wire logic         hresetn,
    // Link signals
    input wire cfgx_index_t  cfg_export_index,
    input wire cfgx_word_t   cfg_export_ctrl_bus,
    input wire logic         cfg_ctrl_update_toggle,
    input wire cfgx_status_t cfg_export_status_bus,
    input wire logic         cfg_status_update_toggle,
    input wire cfgx_hp_t     hotplug_event_inputs
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_index_step;
        $changed(cfg_export_index) |->
            cfg_export_index == cfgx_index_t'($past(cfg_export_index) + 7'h01);
    endproperty
    a_index_step: assert property (p_index_step)
        else $error("index skipped");

    property p_index_period;
        $changed(cfg_export_index) |=>
            $stable(cfg_export_index) [*7] ##1 $changed(cfg_export_index);
    endproperty
    a_index_period: assert property (p_index_period)
        else $error("index period not 8");

    property p_ctrl_hold;
        $changed(cfg_export_ctrl_bus) |-> $changed(cfg_export_index);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("ctrl bus moved without index");

    property p_ctrl_toggle;
        $changed(cfg_export_index) |-> $changed(cfg_ctrl_update_toggle);
    endproperty
    a_ctrl_toggle: assert property (p_ctrl_toggle)
        else $error("ctrl toggle missed");

    property p_ctrl_toggle_only;
        $changed(cfg_ctrl_update_toggle) |-> $changed(cfg_export_index);
    endproperty
    a_ctrl_toggle_only: assert property (p_ctrl_toggle_only)
        else $error("spurious ctrl toggle");

    property p_sts_toggle_pair;
        $changed(cfg_status_update_toggle) |-> $changed(cfg_ctrl_update_toggle);
    endproperty
    a_sts_toggle_pair: assert property (p_sts_toggle_pair)
        else $error("status toggle off tick");

    property p_sts_toggle_period;
        $changed(cfg_status_update_toggle) |=> $stable(cfg_status_update_toggle)
            [*7] ##1 $changed(cfg_status_update_toggle);
    endproperty
    a_sts_toggle_period: assert property (p_sts_toggle_period)
        else $error("status toggle period not 8");

    // Either edge of power status counts as a completed command
    property p_cmd_done;
        $changed(hotplug_event_inputs[4]) |-> ##[1:3] cfg_export_status_bus[47];
    endproperty
    a_cmd_done: assert property (p_cmd_done)
        else $error("command done not reported");

    c_wrap: cover property ($past(cfg_export_index) == 7'h7f
        && cfg_export_index == 7'h00);
    c_power: cover property ($rose(hotplug_event_inputs[4]));
    c_link: cover property ($rose(cfg_export_status_bus[48]));
endmodule : cfgx_link_assertions
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for both ends of the configuration export link
`timescale 1ns/10ps
`default_nettype none
`include "cfgx_params.svh"
module tb_top
    import cfgx_pkg::*;
;
    logic         hclk          = 1'b0;
    logic         hresetn       = 1'b0;
    logic         hsel          = 1'b1;
    logic [31:0]  haddr         = 32'h0;
    logic [1:0]   htrans        = 2'h0;
    logic         hwrite        = 1'b0;
    logic [31:0]  hwdata        = 32'h0;
    logic         hready;
    logic [31:0]  hrdata;
    logic         irq;
    logic         cfg_wr_en     = 1'b0;
    cfgx_index_t  cfg_wr_index  = 7'h0;
    cfgx_word_t   cfg_wr_data   = 32'h0;
    cfgx_status_t sts_in        = 123'h0;
    logic [7:0]   func_en       = 8'hff;
    logic         link_active   = 1'b0;
    logic [1:0]   slot_flag_clr = 2'h0;
    logic         root_port_mode = 1'b1;
    logic         slot_cap_en   = 1'b1;
    logic [1:0]   slot_flags;
    cfgx_hp_t     hotplug_events;
    logic [31:0]  rd;
    int           miscompares   = 0;
    int           compares      = 0;
    int           cyc           = 0;

    cfgx_link_if lk ();
    cfgx_core_end i_cfgx_core_end (.hclk, .hresetn, .lk, .cfg_wr_en,
        .cfg_wr_index, .cfg_wr_data, .sts_in, .func_en, .link_active,
        .root_port_mode, .slot_cap_en, .slot_flag_clr,
        .slot_flags, .hotplug_events);
    cfgx_app_end i_cfgx_app_end (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready),
        .hresp(), .hrdata, .irq, .lk);
    cfgx_link_assertions i_cfgx_link_assertions (.hclk, .hresetn,
        .cfg_export_index(lk.cfg_export_index),
        .cfg_export_ctrl_bus(lk.cfg_export_ctrl_bus),
        .cfg_ctrl_update_toggle(lk.cfg_ctrl_update_toggle),
        .cfg_export_status_bus(lk.cfg_export_status_bus),
        .cfg_status_update_toggle(lk.cfg_status_update_toggle),
        .hotplug_event_inputs(lk.hotplug_event_inputs));

    initial begin
        forever #2 hclk = ~hclk;
    end

    // Cuts a hang short; the full run needs under 4000 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk

    // Entered just after a rising edge; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    function automatic cfgx_word_t tv(input cfgx_index_t i);
        return {8'hc3, 17'h0, i};
    endfunction : tv

    task automatic s_status;
        cfgx_status_t e;
        cfgx_status_t f;
        sts_in <= cfgx_status_t'({4{32'h5a3c96e1}});
        repeat (3) @(posedge hclk);
        e = sts_in;
        // Slot flags own these two bits, not the raw input
        e[48:47] = 2'b00;
        chk(lk.cfg_export_status_bus === e, "status copy");
        func_en <= 8'h82;
        repeat (3) @(posedge hclk);
        f = {e[122:113], 50'h0, e[62:53], 53'h0};
        chk(lk.cfg_export_status_bus === f, "ten-bit groups");
        func_en <= 8'h01;
        repeat (3) @(posedge hclk);
        f = {70'h0, e[52:0]};
        chk(lk.cfg_export_status_bus === f, "function 0 group");
        func_en <= 8'hff;
        repeat (40) @(posedge hclk);
        ahb(1'b0, `CFGX_REG_STS0, 32'h0);
        chk(rd === e[31:0], "captured status");
    endtask : s_status

    task automatic s_walk;
        cfgx_index_t p;
        logic        t;
        int          n;
        for (int i = 0; i < 128; i++) begin
            cfg_wr_en <= 1'b1;
            cfg_wr_index <= 7'(i);
            cfg_wr_data <= tv(7'(i));
            @(posedge hclk);
        end
        cfg_wr_en <= 1'b0;
        p = lk.cfg_export_index;
        t = lk.cfg_status_update_toggle;
        // Past one full wrap of the index
        for (int k = 0; k < 140; k++) begin
            n = 0;
            while (lk.cfg_export_index === p && n < 20) begin
                @(posedge hclk);
                n++;
            end
            chk(lk.cfg_export_index === 7'(p + 7'h01), "index step");
            if (k > 0) chk(n == 8, "index period");
            chk(lk.cfg_export_ctrl_bus === tv(p + 7'h01), "ctrl data");
            chk(lk.cfg_status_update_toggle === ~t, "status toggle");
            p = lk.cfg_export_index;
            t = lk.cfg_status_update_toggle;
        end
    endtask : s_walk

    task automatic s_watch;
        int n;
        ahb(1'b1, `CFGX_REG_WATCH_IDX, 32'h35);
        ahb(1'b1, `CFGX_REG_IRQ_STS, 32'h7);
        ahb(1'b1, `CFGX_REG_IRQ_MASK, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 1200) begin
            @(posedge hclk);
            n++;
        end
        chk(irq === 1'b1, "watch interrupt");
        ahb(1'b0, `CFGX_REG_WATCH_DATA, 32'h0);
        chk(rd === tv(7'h35), "function 3 entry 5");
        ahb(1'b1, `CFGX_REG_IRQ_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        chk(irq === 1'b0, "masked interrupt");
        ahb(1'b0, `CFGX_REG_IRQ_STS, 32'h0);
        chk(rd[0] === 1'b1, "sticky status");
        ahb(1'b1, `CFGX_REG_IRQ_STS, 32'h1);
        @(posedge hclk);
        ahb(1'b0, `CFGX_REG_IRQ_STS, 32'h0);
        chk(rd[0] === 1'b0, "status cleared");
    endtask : s_watch

    task automatic s_hotplug;
        ahb(1'b1, `CFGX_REG_MODE, 32'h0);
        ahb(1'b1, `CFGX_REG_HP_CAP, 32'h7);
        ahb(1'b1, `CFGX_REG_HP_DRIVE, 32'h1f);
        repeat (3) @(posedge hclk);
        chk(lk.hotplug_event_inputs === 5'h1f, "all events");
        chk(hotplug_events === 5'h1f, "events at core");
        root_port_mode <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(hotplug_events === 5'h00, "not root port");
        root_port_mode <= 1'b1;
        slot_cap_en <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(hotplug_events === 5'h00, "no slot");
        slot_cap_en <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(slot_flags[0] === 1'b1, "command done");
        chk(lk.cfg_export_status_bus[47] === 1'b1, "done status");
        ahb(1'b1, `CFGX_REG_HP_CAP, 32'h0);
        repeat (3) @(posedge hclk);
        chk(lk.hotplug_event_inputs === 5'h02, "absent parts");
        ahb(1'b1, `CFGX_REG_MODE, 32'h1);
        repeat (7) @(posedge hclk);
        chk(lk.hotplug_event_inputs === 5'h00, "endpoint zero");
        slot_flag_clr <= 2'b01;
        @(posedge hclk);
        slot_flag_clr <= 2'b00;
        repeat (3) @(posedge hclk);
        chk(slot_flags[0] === 1'b0, "done cleared");
        chk(lk.cfg_export_status_bus[47] === 1'b0, "done status low");
        link_active <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(slot_flags[1] === 1'b1, "link flag");
        chk(lk.cfg_export_status_bus[48] === 1'b1, "link status");
        slot_flag_clr <= 2'b10;
        @(posedge hclk);
        slot_flag_clr <= 2'b00;
        repeat (3) @(posedge hclk);
        chk(slot_flags[1] === 1'b0, "link flag cleared");
    endtask : s_hotplug

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `CFGX_REG_MODE, 32'h0);
        chk(rd[0] === 1'b1, "endpoint at reset");
        ahb(1'b1, 8'h40, 32'hffff_ffff);
        @(posedge hclk);
        ahb(1'b0, 8'h40, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        s_status;
        s_walk;
        s_watch;
        s_hotplug;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
